// file: design/spimsc_pkg.sv
// Constants and types shared by the serial peripheral controller
package spimsc_pkg;

    // ------------------------------------------------------------
    // Register indices (byte address is four times the index)
    // ------------------------------------------------------------
    localparam logic [2:0] IDX_CTRL1 = 3'h0;
    localparam logic [2:0] IDX_CTRL2 = 3'h1;
    localparam logic [2:0] IDX_BAUD = 3'h2;
    localparam logic [2:0] IDX_STAT = 3'h3;
    localparam logic [2:0] IDX_DATA_HI = 3'h4;
    localparam logic [2:0] IDX_DATA_LO = 3'h5;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int C1_IRQ_EN = 7;
    localparam int C1_SYS_EN = 6;
    localparam int C1_TXE_IRQ_EN = 5;
    localparam int C1_MASTER = 4;
    localparam int C1_POL = 3;
    localparam int C1_PHASE = 2;
    localparam int C1_SEL_OE = 1;
    localparam int C1_LOW_FIRST = 0;
    localparam int C2_WIDTH = 6;
    localparam int C2_FAULT_EN = 4;
    localparam int C2_STOP_WAIT = 1;
    localparam int BR_PRE_LSB = 4;
    localparam int BR_SEL_LSB = 0;

    // ------------------------------------------------------------
    // Writable masks, abort masks and reset values
    // ------------------------------------------------------------
    localparam logic [7:0] CTRL2_MASK = 8'h5b;
    localparam logic [7:0] BAUD_MASK = 8'h77;
    localparam logic [7:0] CTRL1_ABORT = 8'h0f;
    localparam logic [7:0] CTRL2_ABORT = 8'h59;
    localparam logic [7:0] CTRL1_RST = 8'h00;
    localparam logic [7:0] CTRL2_RST = 8'h00;
    localparam logic [7:0] BAUD_RST = 8'h00;
    localparam logic [15:0] DATA_RST = 16'h0000;

    // Last edge index of a frame (two edges per bit)
    localparam logic [5:0] LAST_EDGE_8 = 6'h0f;
    localparam logic [5:0] LAST_EDGE_16 = 6'h1f;

    // AXI responses
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef struct packed {
        logic sck;
        logic mosi;
        logic miso;
        logic sel;
    } spimsc_pins_t;

    localparam spimsc_pins_t PINS_IDLE = '{sck: 1'b0, mosi: 1'b0, miso: 1'b0, sel: 1'b1};
    localparam spimsc_pins_t PINS_OFF = '{sck: 1'b0, mosi: 1'b0, miso: 1'b0, sel: 1'b0};

    typedef enum logic [1:0] {
        XF_IDLE = 2'b00,
        XF_MRUN = 2'b01,
        XF_SRUN = 2'b11
    } spimsc_xf_t;

endpackage

// file: design/spimsc_top.sv
// Serial peripheral controller, master or slave, with AXI4-Lite registers
`timescale 1ns/1ns

// Notes on behaviour
// - Wait without stop bit runs as normal
// - Wait with stop bit freezes master clock
// - Slave keeps shifting in wait and stop
// - Stop mode halts master, resumes after
// - MOSI drives as master, samples as slave
// - MISO drives as slave, samples as master
// - Clock output as master, input as slave
// - Reserved bits read zero, writes ignored
// - Irq on done or fault when enabled
// - Disable forces idle, clears done and fault flags
// - Irq while tx empty when enabled
// - Master bit selects role; change idles
// - Polarity sets idle clock level
// - Both ends share one clock polarity
// - Phase picks odd or even sample edges
// - Master format writes abort transfer
// - Low-first bit order; register stays MSB-high
// - Select pin role from fault and output enables
// - Master drives select low during frame
// - Width bit picks 8 or 16 bits
// - Divisor is (pre+1) times 2^(sel+1)
module spimsc_top
    import spimsc_pkg::*;
#(
    parameter int ADDR_W = 8
) (
    // Clock and reset
    input logic REF_CLK_I,
    input logic RST_I,
    // AXI4-Lite write channels
    input logic [ADDR_W-1:0] S_AXI_AWADDR_I,
    input logic S_AXI_AWVALID_I,
    output logic S_AXI_AWREADY_O,
    input logic [31:0] S_AXI_WDATA_I,
    input logic [3:0] S_AXI_WSTRB_I,
    input logic S_AXI_WVALID_I,
    output logic S_AXI_WREADY_O,
    output logic [1:0] S_AXI_BRESP_O,
    output logic S_AXI_BVALID_O,
    input logic S_AXI_BREADY_I,
    // AXI4-Lite read channels
    input logic [ADDR_W-1:0] S_AXI_ARADDR_I,
    input logic S_AXI_ARVALID_I,
    output logic S_AXI_ARREADY_O,
    output logic [31:0] S_AXI_RDATA_O,
    output logic [1:0] S_AXI_RRESP_O,
    output logic S_AXI_RVALID_O,
    input logic S_AXI_RREADY_I,
    // Processor low power state, same clock domain
    input logic WAIT_MODE_I,
    input logic STOP_MODE_I,
    // Serial pins
    input logic SCK_I,
    output logic SCK_O,
    output logic SCK_OE_O,
    input logic MOSI_I,
    output logic MOSI_O,
    output logic MOSI_OE_O,
    input logic MISO_I,
    output logic MISO_O,
    output logic MISO_OE_O,
    input logic SS_I,
    output logic SS_O,
    output logic SS_OE_O,
    // Interrupt request
    output logic IRQ_O
);

    // ------------------------------------------------------------
    // Elaboration check
    // ------------------------------------------------------------
    // Decode needs bits above the eight word slots
    generate
        if (ADDR_W < 6) begin : g_bad_addr
            $error("ADDR_W must be at least 6");
        end
    endgenerate

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    spimsc_pins_t pin_m_r;
    spimsc_pins_t pin_s_r;
    spimsc_pins_t pin_d_r;

    // Two stages, then one more for edge detection on the clean copy
    always_ff @(posedge REF_CLK_I) begin
        if (RST_I) begin
            pin_m_r <= PINS_IDLE;
            pin_s_r <= PINS_IDLE;
            pin_d_r <= PINS_IDLE;
        end else begin
            pin_m_r <= '{sck: SCK_I, mosi: MOSI_I, miso: MISO_I, sel: SS_I};
            pin_s_r <= pin_m_r;
            pin_d_r <= pin_s_r;
        end
    end

    // ------------------------------------------------------------
    // AXI4-Lite slave
    // ------------------------------------------------------------
    logic aw_full_r;
    logic w_full_r;
    logic awready_r;
    logic wready_r;
    logic bvalid_r;
    logic [1:0] bresp_r;
    logic arready_r;
    logic rvalid_r;
    logic [1:0] rresp_r;
    logic [31:0] rdata_r;
    logic [ADDR_W-1:0] aw_addr_r;
    logic [7:0] w_byte_r;
    logic w_lane_r;

    // Address and data are caught in either order; response after both
    wire wr_go = aw_full_r & w_full_r & ~bvalid_r;
    wire aw_take = S_AXI_AWVALID_I & awready_r;
    wire w_take = S_AXI_WVALID_I & wready_r;
    wire aw_full_nxt = wr_go ? 1'b0 : (aw_full_r | aw_take);
    wire w_full_nxt = wr_go ? 1'b0 : (w_full_r | w_take);
    wire ar_take = S_AXI_ARVALID_I & arready_r;
    wire rvalid_nxt = ar_take | (rvalid_r & ~S_AXI_RREADY_I);

    // Word decode; only lane 0 carries register bits
    wire [2:0] w_idx = aw_addr_r[4:2];
    wire w_map = (aw_addr_r[ADDR_W-1:5] == '0);
    wire wr_ok = wr_go & w_map & w_lane_r;
    wire wr_c1 = wr_ok & (w_idx == IDX_CTRL1);
    wire wr_c2 = wr_ok & (w_idx == IDX_CTRL2);
    wire wr_br = wr_ok & (w_idx == IDX_BAUD);
    wire wr_dh = wr_ok & (w_idx == IDX_DATA_HI);
    wire wr_dl = wr_ok & (w_idx == IDX_DATA_LO);
    wire [2:0] r_idx = S_AXI_ARADDR_I[4:2];
    wire r_map = (S_AXI_ARADDR_I[ADDR_W-1:5] == '0);
    wire rd_sr = ar_take & r_map & (r_idx == IDX_STAT);
    wire rd_dl = ar_take & r_map & (r_idx == IDX_DATA_LO);

    // Handshake registers; ready flags mirror the holding slots
    always_ff @(posedge REF_CLK_I) begin
        if (RST_I) begin
            aw_full_r <= 1'b0;
            w_full_r <= 1'b0;
            awready_r <= 1'b1;
            wready_r <= 1'b1;
            bvalid_r <= 1'b0;
            arready_r <= 1'b1;
            rvalid_r <= 1'b0;
        end else begin
            aw_full_r <= aw_full_nxt;
            w_full_r <= w_full_nxt;
            awready_r <= ~aw_full_nxt;
            wready_r <= ~w_full_nxt;
            bvalid_r <= wr_go | (bvalid_r & ~S_AXI_BREADY_I);
            arready_r <= ~rvalid_nxt;
            rvalid_r <= rvalid_nxt;
        end
    end

    // Payload captures
    always_ff @(posedge REF_CLK_I) begin
        if (RST_I) begin
            aw_addr_r <= '0;
            w_byte_r <= 8'h00;
            w_lane_r <= 1'b0;
            bresp_r <= RESP_OKAY;
        end else begin
            if (aw_take) aw_addr_r <= S_AXI_AWADDR_I;
            if (w_take) w_byte_r <= S_AXI_WDATA_I[7:0];
            if (w_take) w_lane_r <= S_AXI_WSTRB_I[0];
            if (wr_go) bresp_r <= w_map ? RESP_OKAY : RESP_SLVERR;
        end
    end

    // ------------------------------------------------------------
    // Control registers and field decode
    // ------------------------------------------------------------
    logic [7:0] c1_r;
    logic [7:0] c2_r;
    logic [7:0] br_r;
    logic [15:0] txb_r;
    logic [15:0] rxb_r;
    logic done_r;
    logic txe_r;
    logic fault_r;
    logic arm_done_r;
    logic arm_txe_r;
    logic arm_fault_r;

    wire en = c1_r[C1_SYS_EN];
    wire master_select = c1_r[C1_MASTER];
    wire clock_polarity = c1_r[C1_POL];
    wire clock_phase = c1_r[C1_PHASE];
    wire select_output_enable = c1_r[C1_SEL_OE];
    wire lsb = c1_r[C1_LOW_FIRST];
    wire w16 = c2_r[C2_WIDTH];
    wire fden = c2_r[C2_FAULT_EN];
    wire swai = c2_r[C2_STOP_WAIT];

    // Master halts in stop, or in wait with the stop bit; slave never does
    wire halt = STOP_MODE_I | (WAIT_MODE_I & swai);

    // Idle forcing: disable, role change, format change as master, fault
    wire mode_chg = wr_c1 & (w_byte_r[C1_MASTER] != master_select);
    wire fmt_c1 = wr_c1 & (((w_byte_r ^ c1_r) & CTRL1_ABORT) != 8'h00);
    wire fmt_c2 = wr_c2 & (((w_byte_r ^ c2_r) & CTRL2_ABORT) != 8'h00);
    wire fmt_br = wr_br & (((w_byte_r & BAUD_MASK) ^ br_r) != 8'h00);
    wire fmt_hit = master_select & (fmt_c1 | fmt_c2 | fmt_br);
    wire fault_evt = en & master_select & fden & ~select_output_enable & ~pin_s_r.sel;
    wire force_idle = ~en | mode_chg | fmt_hit | fault_evt;

    // Masked register writes keep reserved bits at zero
    always_ff @(posedge REF_CLK_I) begin
        if (RST_I) begin
            c1_r <= CTRL1_RST;
            c2_r <= CTRL2_RST;
            br_r <= BAUD_RST;
            txb_r <= DATA_RST;
        end else begin
            if (wr_c1) c1_r <= w_byte_r;
            if (wr_c2) c2_r <= w_byte_r & CTRL2_MASK;
            if (wr_br) br_r <= w_byte_r & BAUD_MASK;
            if (wr_dh) txb_r[15:8] <= w_byte_r;
            if (wr_dl) txb_r[7:0] <= w_byte_r;
        end
    end

    // ------------------------------------------------------------
    // Transfer engine
    // ------------------------------------------------------------
    spimsc_xf_t xf_r;
    spimsc_xf_t xf_nxt;
    logic [5:0] cnt_r;
    logic [5:0] cnt_nxt;
    logic [10:0] div_r;
    logic [10:0] div_nxt;
    logic [15:0] txs_r;
    logic [15:0] txs_nxt;
    logic [15:0] rxs_r;
    logic [15:0] rxs_nxt;
    logic lvl_r;
    logic lvl_nxt;
    logic xdone;
    logic load;

    // Half period is half the divisor: (pre+1) shifted by sel
    wire [3:0] pre_p1 = {1'b0, br_r[BR_PRE_LSB +: 3]} + 4'h1;
    wire [10:0] half_w = {7'h00, pre_p1} << br_r[BR_SEL_LSB +: 3];
    wire [10:0] half_m1 = half_w - 11'h001;

    // Edge sources: own divider as master, synced pin as slave
    wire m_tick = (xf_r == XF_MRUN) & ~halt & (div_r == half_m1);
    wire s_edge = (xf_r == XF_SRUN) & (pin_s_r.sck ^ pin_d_r.sck);
    wire any_edge = m_tick | s_edge;
    wire samp_edge = any_edge & (cnt_r[0] == clock_phase);
    wire shift_edge = any_edge & (cnt_r[0] != clock_phase) & (cnt_r != 6'h00);
    wire [5:0] last_cnt = w16 ? LAST_EDGE_16 : LAST_EDGE_8;
    wire last_edge = any_edge & (cnt_r == last_cnt);
    wire in_bit = master_select ? pin_s_r.miso : pin_s_r.mosi;
    wire ss_fall = pin_d_r.sel & ~pin_s_r.sel;
    wire idle = (xf_r == XF_IDLE);
    wire m_start = idle & en & master_select & ~txe_r & ~halt & ~force_idle;
    wire s_start = idle & en & ~master_select & ss_fall & ~force_idle;

    // Sequencing of one frame; counters freeze while the master halts
    always_comb begin
        xf_nxt = xf_r;
        cnt_nxt = cnt_r;
        div_nxt = div_r;
        txs_nxt = txs_r;
        rxs_nxt = rxs_r;
        lvl_nxt = lvl_r;
        xdone = 1'b0;
        load = 1'b0;
        unique case (xf_r)
            XF_IDLE: begin
                cnt_nxt = 6'h00;
                div_nxt = 11'h000;
                lvl_nxt = 1'b0;
                if (m_start) begin
                    xf_nxt = XF_MRUN;
                    load = 1'b1;
                end else if (s_start) begin
                    xf_nxt = XF_SRUN;
                    load = 1'b1;
                end
            end
            XF_MRUN, XF_SRUN: begin
                if ((xf_r == XF_MRUN) && !halt) begin
                    div_nxt = (div_r == half_m1) ? 11'h000 : div_r + 11'h001;
                end
                if (any_edge) begin
                    cnt_nxt = cnt_r + 6'h01;
                    lvl_nxt = ~lvl_r;
                end
                if (samp_edge) begin
                    rxs_nxt = lsb ? {in_bit, rxs_r[15:1]} : {rxs_r[14:0], in_bit};
                end
                if (shift_edge) begin
                    txs_nxt = lsb ? {1'b0, txs_r[15:1]} : {txs_r[14:0], 1'b0};
                end
                if (last_edge) begin
                    xf_nxt = XF_IDLE;
                    xdone = 1'b1;
                end
                // Select released mid-frame ends the slave frame
                if ((xf_r == XF_SRUN) && pin_s_r.sel) begin
                    xf_nxt = XF_IDLE;
                end
            end
            default: xf_nxt = XF_IDLE;
        endcase
        if (load) begin
            txs_nxt = txb_r;
        end
        if (force_idle) begin
            xf_nxt = XF_IDLE;
            xdone = 1'b0;
        end
    end

    // Received word lands with MSB in the top bit in both orders
    wire [15:0] rx_word = w16 ? rxs_nxt :
        (lsb ? {8'h00, rxs_nxt[15:8]} : {8'h00, rxs_nxt[7:0]});
    wire out_nxt = lsb ? txs_nxt[0] : (w16 ? txs_nxt[15] : txs_nxt[7]);

    always_ff @(posedge REF_CLK_I) begin
        if (RST_I) begin
            xf_r <= XF_IDLE;
            cnt_r <= 6'h00;
            div_r <= 11'h000;
            txs_r <= DATA_RST;
            rxs_r <= DATA_RST;
            lvl_r <= 1'b0;
            rxb_r <= DATA_RST;
        end else begin
            xf_r <= xf_nxt;
            cnt_r <= cnt_nxt;
            div_r <= div_nxt;
            txs_r <= txs_nxt;
            rxs_r <= rxs_nxt;
            lvl_r <= lvl_nxt;
            if (xdone) rxb_r <= rx_word;
        end
    end

    // ------------------------------------------------------------
    // Status flags
    // ------------------------------------------------------------
    // Clearing takes a status read with the flag up, then the data
    // access, or a CTRL1 write for fault; a new event in the clearing cycle wins
    always_ff @(posedge REF_CLK_I) begin
        if (RST_I || !en) begin
            done_r <= 1'b0;
            txe_r <= 1'b1;
            fault_r <= 1'b0;
            arm_done_r <= 1'b0;
            arm_txe_r <= 1'b0;
            arm_fault_r <= 1'b0;
        end else begin
            done_r <= xdone | (done_r & ~(rd_dl & arm_done_r));
            txe_r <= load | (txe_r & ~(wr_dl & arm_txe_r));
            fault_r <= fault_evt | (fault_r & ~(wr_c1 & arm_fault_r));
            arm_done_r <= (arm_done_r & ~rd_dl) | (rd_sr & done_r);
            arm_txe_r <= (arm_txe_r & ~wr_dl) | (rd_sr & txe_r);
            arm_fault_r <= (arm_fault_r & ~wr_c1) | (rd_sr & fault_r);
        end
    end

    // ------------------------------------------------------------
    // Read data and pin drive
    // ------------------------------------------------------------
    // Reserved bits and unused slots read as zero
    wire [7:0] sr_val = {done_r, 1'b0, txe_r, fault_r, 4'h0};
    wire [7:0] rd_byte = (r_idx == IDX_CTRL1) ? c1_r :
        (r_idx == IDX_CTRL2) ? c2_r :
        (r_idx == IDX_BAUD) ? br_r :
        (r_idx == IDX_STAT) ? sr_val :
        (r_idx == IDX_DATA_HI) ? (w16 ? rxb_r[15:8] : 8'h00) :
        (r_idx == IDX_DATA_LO) ? rxb_r[7:0] : 8'h00;

    // Pin levels follow the next state so drive does not lag the engine
    spimsc_pins_t po_r;
    spimsc_pins_t poe_r;
    logic irq_r;
    wire sel_out = en & master_select & fden & select_output_enable;
    wire irq_nxt = en & ((c1_r[C1_IRQ_EN] & (done_r | fault_r)) |
        (c1_r[C1_TXE_IRQ_EN] & txe_r));

    always_ff @(posedge REF_CLK_I) begin
        if (RST_I) begin
            po_r <= PINS_IDLE;
            poe_r <= PINS_OFF;
            irq_r <= 1'b0;
            rdata_r <= 32'h0000_0000;
            rresp_r <= RESP_OKAY;
        end else begin
            po_r.sck <= clock_polarity ^ lvl_nxt;
            po_r.mosi <= out_nxt;
            po_r.miso <= out_nxt;
            po_r.sel <= (xf_nxt != XF_MRUN);
            poe_r.sck <= en & master_select;
            poe_r.mosi <= en & master_select;
            poe_r.miso <= en & ~master_select & ~pin_s_r.sel;
            poe_r.sel <= sel_out;
            irq_r <= irq_nxt;
            if (ar_take) rdata_r <= {24'h00_0000, r_map ? rd_byte : 8'h00};
            if (ar_take) rresp_r <= r_map ? RESP_OKAY : RESP_SLVERR;
        end
    end

    // Port drive straight from flip-flops
    assign S_AXI_AWREADY_O = awready_r;
    assign S_AXI_WREADY_O = wready_r;
    assign S_AXI_BVALID_O = bvalid_r;
    assign S_AXI_BRESP_O = bresp_r;
    assign S_AXI_ARREADY_O = arready_r;
    assign S_AXI_RVALID_O = rvalid_r;
    assign S_AXI_RRESP_O = rresp_r;
    assign S_AXI_RDATA_O = rdata_r;
    assign SCK_O = po_r.sck;
    assign SCK_OE_O = poe_r.sck;
    assign MOSI_O = po_r.mosi;
    assign MOSI_OE_O = poe_r.mosi;
    assign MISO_O = po_r.miso;
    assign MISO_OE_O = poe_r.miso;
    assign SS_O = po_r.sel;
    assign SS_OE_O = poe_r.sel;
    assign IRQ_O = irq_r;

endmodule

// file: test/spimsc_assertions.sv
// Port-level checks on the serial controller
`timescale 1ns/1ns
module spimsc_assertions
    import spimsc_pkg::*;
#(
    parameter int ADDR_W = 8
) (
    // Clock and reset
    input wire logic REF_CLK_I,
    input wire logic RST_I,
    // Register bus
    input wire logic S_AXI_AWVALID_I,
    input wire logic S_AXI_AWREADY_O,
    input wire logic S_AXI_BVALID_O,
    input wire logic S_AXI_BREADY_I,
    input wire logic [ADDR_W-1:0] S_AXI_ARADDR_I,
    input wire logic S_AXI_ARVALID_I,
    input wire logic S_AXI_ARREADY_O,
    input wire logic [31:0] S_AXI_RDATA_O,
    input wire logic [1:0] S_AXI_RRESP_O,
    input wire logic S_AXI_RVALID_O,
    input wire logic S_AXI_RREADY_I,
    // Power state and pins
    input wire logic STOP_MODE_I,
    input wire logic SCK_O,
    input wire logic SCK_OE_O,
    input wire logic MOSI_OE_O,
    input wire logic MISO_OE_O,
    input wire logic SS_OE_O
);
    default clocking cb @(posedge REF_CLK_I); endclocking
    default disable iff (RST_I);

    // ------------------------------------------------------------
    // Bus answers
    // ------------------------------------------------------------
    rd_hold_a:
        assert property (S_AXI_RVALID_O && !S_AXI_RREADY_I |=> S_AXI_RVALID_O
            && $stable(S_AXI_RDATA_O)) else $error("read answer not held");
    wr_hold_a:
        assert property (S_AXI_BVALID_O && !S_AXI_BREADY_I |=> S_AXI_BVALID_O)
            else $error("write answer not held");
    rd_latency_a:
        assert property (S_AXI_ARVALID_I && S_AXI_ARREADY_O |=> S_AXI_RVALID_O)
            else $error("read answer late");
    wr_latency_a:
        assert property (S_AXI_AWVALID_I && S_AXI_AWREADY_O |-> ##[1:4] S_AXI_BVALID_O)
            else $error("write answer late");
    ar_block_a:
        assert property (S_AXI_RVALID_O |-> !S_AXI_ARREADY_O)
            else $error("read taken while answer pending");
    upper_zero_a:
        assert property (S_AXI_RVALID_O |-> S_AXI_RDATA_O[31:8] == 24'h0)
            else $error("unused read bits not zero");
    unmap_err_a:
        assert property (S_AXI_ARVALID_I && S_AXI_ARREADY_O && S_AXI_ARADDR_I[ADDR_W-1:5] != 0
            |=> S_AXI_RRESP_O == RESP_SLVERR && S_AXI_RDATA_O == 32'h0)
            else $error("unmapped read answered wrongly");
    // ------------------------------------------------------------
    // Pin roles and halt
    // ------------------------------------------------------------
    pin_role_a:
        assert property (MOSI_OE_O |-> SCK_OE_O && !MISO_OE_O)
            else $error("master pin directions wrong");
    sel_role_a:
        assert property (SS_OE_O |-> MOSI_OE_O) else $error("select driven outside master");
    // Pins lag by one register, so the freeze shows two edges after stop
    halt_sck_a:
        assert property (SCK_OE_O && STOP_MODE_I && $past(STOP_MODE_I)
            && $past(STOP_MODE_I, 2) |-> $stable(SCK_O)) else $error("clock moved in stop");
endmodule

// file: test/spimsc_peer.sv
// External serial slave model, idle-low clock, odd-edge sampling, MSB first
`timescale 1ns/1ns
module spimsc_peer (
    // Pins
    input wire logic sck_i,
    input wire logic mosi_i,
    input wire logic ss_n_i,
    output logic miso_o,
    // Data
    input wire logic [7:0] tx_i,
    output logic [7:0] rx_o
);
    logic [7:0] sh_r = 8'h00;

    initial miso_o = 1'b0;
    initial rx_o = 8'h00;
    // First bit is out before the first edge
    always @(negedge ss_n_i) begin
        sh_r = tx_i;
        miso_o = tx_i[7];
    end
    // Same polarity as the controller: sample on rising edges
    always @(posedge sck_i) begin
        if (!ss_n_i) rx_o = {rx_o[6:0], mosi_i};
    end
    // Next bit on falling edges
    always @(negedge sck_i) begin
        if (!ss_n_i) begin
            sh_r = sh_r << 1;
            miso_o = sh_r[7];
        end
    end
    // Released line flips, so a stale bit is never read as good
    always @(posedge ss_n_i) miso_o = ~miso_o;
endmodule

// file: test/spimsc_top_bench.sv
// Register-level bench for the serial controller as master
`timescale 1ns/1ns
module spimsc_top_bench;
    import spimsc_pkg::*;
    logic clk = 1'b0, rst = 1'b1, awv = 1'b0, wv = 1'b0, bready = 1'b0;
    logic arv = 1'b0, rready = 1'b0, stop_m = 1'b0, ss_drv = 1'b1, wait_m = 1'b0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00, v, peer_rx;
    logic [31:0] wdata = 32'h0, rdata;
    logic awready, wready, bvalid, arready, rvalid, irq, sck, sck_oe, mosi, mosi_oe;
    logic miso, miso_oe, ss, ss_oe, peer_miso, ss_w;
    logic [1:0] bresp, rresp, rsp;
    logic [7:0] ra [5] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h18};
    logic [7:0] re [5] = '{8'h00, 8'h00, 8'h00, 8'h20, 8'h00};
    logic [7:0] pr [2] = '{8'h3a, 8'h5c};
    logic [7:0] dr [2] = '{8'hc5, 8'ha3};
    int num_errors = 0, checked = 0, n;

    always #10 clk = ~clk;
    // Select pin has a pull-up when not driven
    assign ss_w = ss_oe ? ss : ss_drv;

    spimsc_top dut (
        .REF_CLK_I(clk), .RST_I(rst), .S_AXI_AWADDR_I(awaddr), .S_AXI_AWVALID_I(awv),
        .S_AXI_AWREADY_O(awready), .S_AXI_WDATA_I(wdata), .S_AXI_WSTRB_I(4'hf),
        .S_AXI_WVALID_I(wv), .S_AXI_WREADY_O(wready), .S_AXI_BRESP_O(bresp),
        .S_AXI_BVALID_O(bvalid), .S_AXI_BREADY_I(bready), .S_AXI_ARADDR_I(araddr),
        .S_AXI_ARVALID_I(arv), .S_AXI_ARREADY_O(arready), .S_AXI_RDATA_O(rdata),
        .S_AXI_RRESP_O(rresp), .S_AXI_RVALID_O(rvalid), .S_AXI_RREADY_I(rready),
        .WAIT_MODE_I(wait_m), .STOP_MODE_I(stop_m), .SCK_I(sck), .SCK_O(sck),
        .SCK_OE_O(sck_oe), .MOSI_I(mosi), .MOSI_O(mosi), .MOSI_OE_O(mosi_oe),
        .MISO_I(peer_miso), .MISO_O(miso), .MISO_OE_O(miso_oe), .SS_I(ss_w), .SS_O(ss),
        .SS_OE_O(ss_oe), .IRQ_O(irq));
    spimsc_peer peer (.sck_i(sck), .mosi_i(mosi), .ss_n_i(ss_w), .miso_o(peer_miso),
        .tx_i(8'hc5), .rx_o(peer_rx));

    task chk(input string nm, input logic [7:0] s, input logic [7:0] e);
        checked++;
        if (s !== e) begin
            num_errors++;
            $display("mismatch %s expected %h seen %h", nm, e, s);
        end
    endtask
    task end_sim;
        $display("checked %0d num_errors %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task tmo(input int k);
        if (k >= 200) begin
            num_errors++;
            $display("mismatch wait bound expected 0 seen 1");
            end_sim;
        end
    endtask
    // Write: address and data offered together, each dropped once taken
    task wr(input logic [7:0] a, input logic [7:0] d);
        int k;
        k = 0;
        @(posedge clk);
        awaddr <= a;
        wdata <= {24'h0, d};
        awv <= 1'b1;
        wv <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge clk);
            k++;
            if (awready) awv <= 1'b0;
            if (wready) wv <= 1'b0;
        end while (!bvalid && k < 200);
        bready <= 1'b0;
        tmo(k);
    endtask
    task rd(input logic [7:0] a, output logic [7:0] d);
        int k;
        k = 0;
        @(posedge clk);
        araddr <= a;
        arv <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge clk);
            k++;
            if (arready) arv <= 1'b0;
        end while (!rvalid && k < 200);
        d = rdata[7:0];
        rsp = rresp;
        rready <= 1'b0;
        tmo(k);
    endtask

    initial begin
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        // Reset values, then masks of writable bits and the reserved place
        for (int k = 0; k < 5; k++) begin
            rd(ra[k], v);
            chk("reset value", v, re[k]);
        end
        wr(8'h08, 8'hff);
        wr(8'h0c, 8'hff);
        wr(8'h18, 8'hff);
        wr(8'h04, 8'hff);
        rd(8'h04, v);
        chk("ctrl2 mask", v, CTRL2_MASK);
        rd(8'h08, v);
        chk("baud mask", v, BAUD_MASK);
        rd(8'h18, v);
        chk("reserved", v, 8'h00);
        rd(8'h0c, v);
        chk("status ro", v, 8'h20);
        rd(8'h20, v);
        chk("unmapped resp", {6'h0, rsp}, {6'h0, RESP_SLVERR});
        // Master, fault input enabled with select output, slow clock
        wr(8'h04, 8'h10);
        wr(8'h08, 8'h03);
        wr(8'h00, 8'h72);
        repeat (3) @(posedge clk);
        chk("irq tx empty", {7'h0, irq}, 8'h01);
        chk("master oe", {5'h0, sck_oe, mosi_oe, miso_oe}, 8'h06);
        // Wait without the stop bit must not disturb either frame
        wait_m <= 1'b1;
        for (int b = 0; b < 2; b++) begin
            wr(8'h00, 8'hd2 | 8'(b));
            rd(8'h0c, v);
            wr(8'h14, 8'h3a);
            // Second frame is frozen in its third bit and must still finish correctly
            if (b == 1) begin
                repeat (40) @(posedge clk);
                stop_m <= 1'b1;
                repeat (100) @(posedge clk);
                chk("ss in frame", {7'h0, ss}, 8'h00);
                stop_m <= 1'b0;
            end
            n = 0;
            do begin
                rd(8'h0c, v);
                n++;
            end while (v[7] !== 1'b1 && n < 200);
            tmo(n);
            chk("irq done", {7'h0, irq}, 8'h01);
            chk("sck idle", {7'h0, sck}, 8'h00);
            chk("peer rx", peer_rx, pr[b]);
            rd(8'h14, v);
            chk("rx data", v, dr[b]);
            rd(8'h0c, v);
            chk("status clear", v, 8'h20);
        end
        wait_m <= 1'b0;
        // Select as fault input pulled low
        wr(8'h00, 8'hd0);
        ss_drv <= 1'b0;
        repeat (6) @(posedge clk);
        rd(8'h0c, v);
        chk("fault flag", v, 8'h30);
        chk("irq fault", {7'h0, irq}, 8'h01);
        ss_drv <= 1'b1;
        wr(8'h00, 8'h00);
        rd(8'h0c, v);
        chk("disable flags", v, 8'h20);
        end_sim;
    end
endmodule

bind spimsc_top spimsc_assertions #(.ADDR_W(ADDR_W)) u_chk (
    .REF_CLK_I(REF_CLK_I), .RST_I(RST_I), .S_AXI_AWVALID_I(S_AXI_AWVALID_I),
    .S_AXI_AWREADY_O(S_AXI_AWREADY_O), .S_AXI_BVALID_O(S_AXI_BVALID_O),
    .S_AXI_BREADY_I(S_AXI_BREADY_I), .S_AXI_ARADDR_I(S_AXI_ARADDR_I),
    .S_AXI_ARVALID_I(S_AXI_ARVALID_I), .S_AXI_ARREADY_O(S_AXI_ARREADY_O),
    .S_AXI_RDATA_O(S_AXI_RDATA_O), .S_AXI_RRESP_O(S_AXI_RRESP_O),
    .S_AXI_RVALID_O(S_AXI_RVALID_O), .S_AXI_RREADY_I(S_AXI_RREADY_I),
    .STOP_MODE_I(STOP_MODE_I), .SCK_O(SCK_O), .SCK_OE_O(SCK_OE_O),
    .MOSI_OE_O(MOSI_OE_O), .MISO_OE_O(MISO_OE_O), .SS_OE_O(SS_OE_O));
